/* File: hdl/spf_self_program_flash_control.v */
`timescale 1ns/1ns
`default_nettype none
`include "spf_defs.vh"
module spf_self_program_flash_control #(
  parameter [31:0] PROG_CYCLES = `SPF_PROG_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Register port
  input  wire [3:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  // Processor instruction side
  input  wire        store_program_instruction_i,
  input  wire        load_program_instruction_i,
  input  wire [15:0] z_ptr_i,
  input  wire [7:0]  r0_i,
  input  wire [7:0]  r1_i,
  input  wire        global_int_en_i,
  input  wire        exec_in_boot_i,
  input  wire        vectors_in_boot_i,
  input  wire        target_in_boot_i,
  input  wire        target_in_no_read_while_write_section_i,
  input  wire [7:0]  fuse_byte_i,
  input  wire        chip_erase_i,
  // Flash array side
  output reg         flash_erase_o,
  output reg         flash_write_o,
  output reg  [6:0]  flash_page_o,
  input  wire [5:0]  flash_word_i,
  output wire [15:0] flash_wdata_o,
  // Processor status
  output wire        cpu_stall_o,
  output reg  [7:0]  load_data_o,
  output reg         load_special_o,
  output wire        store_refused_o,
  output wire        load_refused_o,
  output wire        int_block_o,
  output wire        rww_access_block_o,
  output wire        ext_prog_block_o,
  output wire        ext_verify_block_o,
  output wire        fuse_lock_o,
  output wire        boot_lock_lock_o,
  output wire        ready_irq_o
);
  // --------------------------------------------------------------------
  // Control state
  // --------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ARM  = 2'b01;
  localparam [1:0] ST_PROG = 2'b10;

  reg  [1:0] state;
  reg  [2:0] arm_cnt;
  reg  [4:0] cmd;
  reg        ready_interrupt_enable;
  reg        rw_section_busy;
  reg        loading;
  reg        prog_no_read_while_write_section;
  reg  [7:0] lock_byte;
  reg        prog_start;
  reg        buf_wr;
  reg        buf_clear;
  wire       prog_busy;
  wire       prog_done;

  wire store_enable = (state != ST_IDLE);
  wire pat_ok = (reg_wdata_i[4:0] == `SPF_PAT_REEN)
             || (reg_wdata_i[4:0] == `SPF_PAT_LOCK)
             || (reg_wdata_i[4:0] == `SPF_PAT_PWR)
             || (reg_wdata_i[4:0] == `SPF_PAT_PER)
             || (reg_wdata_i[4:0] == `SPF_PAT_FILL);
  wire csr_wr = reg_wr_i && (reg_addr_i == `SPF_ADDR_CSR);
  wire cmd_wr = csr_wr && pat_ok && (state == ST_IDLE);

  // --------------------------------------------------------------------
  // Lock decode
  // --------------------------------------------------------------------
  wire general_lock_lo   = lock_byte[0];
  wire general_lock_hi   = lock_byte[1];
  wire app_sect_lock_lo  = lock_byte[2];
  wire app_sect_lock_hi  = lock_byte[3];
  wire boot_sect_lock_lo = lock_byte[4];
  wire boot_sect_lock_hi = lock_byte[5];

  assign ext_prog_block_o   = !general_lock_lo;
  assign fuse_lock_o        = !general_lock_lo;
  assign ext_verify_block_o = !general_lock_lo && !general_lock_hi;
  assign boot_lock_lock_o   = !general_lock_lo && !general_lock_hi;

  wire app_no_store  = !app_sect_lock_lo && app_sect_lock_hi
                    || !app_sect_lock_lo && !app_sect_lock_hi;
  wire app_no_load   = !app_sect_lock_hi;
  wire boot_no_store = !boot_sect_lock_lo;
  wire boot_no_load  = !boot_sect_lock_hi;

  wire store_denied = target_in_boot_i ? boot_no_store : app_no_store;
  assign store_refused_o = store_program_instruction_i && store_enable
                        && (cmd[2] || cmd[1]) && store_denied;
  assign load_refused_o = load_program_instruction_i
    && ((exec_in_boot_i && !target_in_boot_i && app_no_load)
     || (!exec_in_boot_i && target_in_boot_i && boot_no_load));
  assign int_block_o =
       (vectors_in_boot_i && !exec_in_boot_i && app_no_load)
    || (!vectors_in_boot_i && exec_in_boot_i && boot_no_load);

  // --------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------
  assign ready_irq_o = ready_interrupt_enable && global_int_en_i
                    && !store_enable;
  assign rww_access_block_o = rw_section_busy;
  assign cpu_stall_o = (state == ST_PROG) && prog_no_read_while_write_section;

  wire [7:0] csr_view = {ready_interrupt_enable, rw_section_busy,
                         1'b0, cmd[4:1], store_enable};

  wire store_go = store_program_instruction_i && (state == ST_ARM);

  // --------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state                  <= ST_IDLE;
      arm_cnt                <= 3'h0;
      cmd                    <= 5'h00;
      ready_interrupt_enable <= 1'b0;
      rw_section_busy        <= 1'b0;
      loading                <= 1'b0;
      prog_no_read_while_write_section              <= 1'b0;
      lock_byte              <= `SPF_LOCK_RST;
      prog_start             <= 1'b0;
      buf_wr                 <= 1'b0;
      buf_clear              <= 1'b0;
      flash_erase_o          <= 1'b0;
      flash_write_o          <= 1'b0;
      flash_page_o           <= 7'h00;
    end else begin
      prog_start <= 1'b0;
      buf_wr     <= 1'b0;
      buf_clear  <= 1'b0;
      if (csr_wr) begin
        ready_interrupt_enable <= reg_wdata_i[`SPF_BIT_IE];
      end
      if (chip_erase_i) begin
        lock_byte <= `SPF_LOCK_RST;
      end
      case (state)
        ST_IDLE: begin
          if (cmd_wr) begin
            cmd     <= reg_wdata_i[4:0];
            arm_cnt <= `SPF_ARM_CYC;
            state   <= ST_ARM;
            if (reg_wdata_i[`SPF_BIT_REEN] && loading) begin
              loading   <= 1'b0;
              buf_clear <= 1'b1;
            end
          end
        end
        ST_ARM: begin
          if (store_go) begin
            if (cmd[`SPF_BIT_REEN]) begin
              rw_section_busy <= 1'b0;
              cmd   <= 5'h00;
              state <= ST_IDLE;
            end else if (cmd[`SPF_BIT_LOCK]) begin
              // Programming only moves bits toward zero
              lock_byte <= lock_byte & {2'b11, r0_i[5:0]};
              cmd   <= 5'h00;
              state <= ST_IDLE;
            end else if ((cmd[`SPF_BIT_PWR] || cmd[`SPF_BIT_PER])
                         && !store_denied) begin
              flash_page_o  <= z_ptr_i[`SPF_PAGE_HI:`SPF_PAGE_LO];
              flash_erase_o <= cmd[`SPF_BIT_PER];
              flash_write_o <= cmd[`SPF_BIT_PWR];
              prog_no_read_while_write_section     <= target_in_no_read_while_write_section_i;
              if (!target_in_no_read_while_write_section_i) begin
                rw_section_busy <= 1'b1;
              end
              if (cmd[`SPF_BIT_PWR]) begin
                loading <= 1'b0;
              end
              prog_start <= 1'b1;
              state      <= ST_PROG;
            end else if (cmd == `SPF_PAT_FILL) begin
              buf_wr          <= 1'b1;
              loading         <= 1'b1;
              rw_section_busy <= 1'b0;
              cmd   <= 5'h00;
              state <= ST_IDLE;
            end else begin
              cmd   <= 5'h00;
              state <= ST_IDLE;
            end
          end else if (arm_cnt == 3'h1) begin
            cmd   <= 5'h00;
            state <= ST_IDLE;
          end else begin
            arm_cnt <= arm_cnt - 3'h1;
          end
        end
        ST_PROG: begin
          if (prog_done) begin
            flash_erase_o <= 1'b0;
            flash_write_o <= 1'b0;
            prog_no_read_while_write_section     <= 1'b0;
            cmd           <= 5'h00;
            state         <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Special load within three cycles of the lock command
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_data_o    <= 8'h00;
      load_special_o <= 1'b0;
    end else begin
      load_special_o <= 1'b0;
      if (load_program_instruction_i && (state == ST_ARM)
          && (cmd == `SPF_PAT_LOCK)
          && (arm_cnt > (`SPF_ARM_CYC - `SPF_LPM_CYC))) begin
        load_special_o <= 1'b1;
        load_data_o <= z_ptr_i[0] ? fuse_byte_i : lock_byte;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SPF_ADDR_CSR:    reg_rdata_o <= csr_view;
        `SPF_ADDR_LOCK:   reg_rdata_o <= lock_byte;
        `SPF_ADDR_STATUS: reg_rdata_o <= {5'h00, loading, prog_busy,
                                          prog_no_read_while_write_section};
        default:          reg_rdata_o <= 8'h00;
      endcase
    end
  end

  reg [15:0] z_ptr_d;
  reg [15:0] wdata_d;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      z_ptr_d <= 16'h0000;
      wdata_d <= 16'h0000;
    end else if (store_go) begin
      z_ptr_d <= z_ptr_i;
      wdata_d <= {r1_i, r0_i};
    end
  end

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  spf_page_buffer u_buf (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (buf_wr),
    .waddr_i   (z_ptr_d[`SPF_WORD_HI:`SPF_WORD_LO]),
    .wdata_i   (wdata_d),
    .clear_i   (buf_clear || (state == ST_PROG && prog_done && flash_write_o)),
    .raddr_i   (flash_word_i),
    .rdata_o   (flash_wdata_o)
  );

  spf_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (prog_start),
    .busy_o    (prog_busy),
    .done_o    (prog_done)
  );
endmodule // spf_self_program_flash_control
`default_nettype wire

/* File: hdl/spf_defs.vh */
`ifndef SPF_DEFS_VH
`define SPF_DEFS_VH
// ----------------------------------------------------------------------
// Register access and control fields
// ----------------------------------------------------------------------
`define SPF_ADDR_W         4
`define SPF_ADDR_CSR       4'h0
`define SPF_ADDR_LOCK      4'h1
`define SPF_ADDR_STATUS    4'h2
`define SPF_BIT_IE         7
`define SPF_BIT_BUSY       6
`define SPF_BIT_REEN       4
`define SPF_BIT_LOCK       3
`define SPF_BIT_PWR        2
`define SPF_BIT_PER        1
`define SPF_BIT_SEN        0
`define SPF_PAT_REEN       5'h11
`define SPF_PAT_LOCK       5'h09
`define SPF_PAT_PWR        5'h05
`define SPF_PAT_PER        5'h03
`define SPF_PAT_FILL       5'h01
`define SPF_LOCK_RST       8'hFF
// ----------------------------------------------------------------------
// Z pointer layout and timing
// ----------------------------------------------------------------------
`define SPF_PAGE_HI        13
`define SPF_PAGE_LO        7
`define SPF_WORD_HI        6
`define SPF_WORD_LO        1
`define SPF_ARM_CYC        3'h4
`define SPF_LPM_CYC        3'h3
`define SPF_CLK_MHZ        125
`define SPF_PROG_US        4000
`define SPF_PROG_CYC       (`SPF_PROG_US * `SPF_CLK_MHZ)
`endif

/* File: hdl/spf_page_buffer.v */
`timescale 1ns/1ns
`default_nettype none
`include "spf_defs.vh"
module spf_page_buffer (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Fill and clear
  input  wire        wr_i,
  input  wire [5:0]  waddr_i,
  input  wire [15:0] wdata_i,
  input  wire        clear_i,
  // Read
  input  wire [5:0]  raddr_i,
  output reg  [15:0] rdata_o
);
  reg [15:0] mem [0:63];
  reg [63:0] vld;
  always @(posedge clk_i) begin
    if (sys_rst_i || clear_i) begin
      vld <= 64'h0000_0000_0000_0000;
    end else if (wr_i) begin
      vld[waddr_i] <= 1'b1;
    end
    if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
  // Discarded words read as erased
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 16'hFFFF;
    end else begin
      rdata_o <= vld[raddr_i] ? mem[raddr_i] : 16'hFFFF;
    end
  end
endmodule // spf_page_buffer
`default_nettype wire

/* File: hdl/spf_prog_timer.v */
`timescale 1ns/1ns
`default_nettype none
module spf_prog_timer #(
  parameter [31:0] CYCLES = 32'h0007_A120
) (
  // Clock and reset
  input  wire clk_i,
  input  wire sys_rst_i,
  // Control
  input  wire start_i,
  output wire busy_o,
  output reg  done_o
);
  reg [31:0] cnt;
  assign busy_o = (cnt != 32'h0000_0000);
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt    <= 32'h0000_0000;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt == 32'h0000_0001);
      if (start_i && !busy_o) begin
        cnt <= CYCLES;
      end else if (busy_o) begin
        cnt <= cnt - 32'h0000_0001;
      end
    end
  end
endmodule // spf_prog_timer
`default_nettype wire

/* File: testbench/spf_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------
// Processor core issuing store and load program instructions
// --------------------------------------------------------------
module spf_core_model (
  // Clock
  input  wire logic        clk_i,
  // Instruction side
  output logic             store_o,
  output logic             load_o,
  output logic [15:0]      z_o,
  output logic [7:0]       r0_o,
  output logic [7:0]       r1_o,
  output logic             no_read_while_write_section_o
);
  initial begin
    store_o = 1'b0;
    load_o = 1'b0;
    z_o = 16'h0000;
    {r1_o, r0_o} = 16'h0000;
    no_read_while_write_section_o = 1'b0;
  end

  // One instruction after dly idle cycles
  task automatic issue(input logic ld, input int dly, input logic [15:0] z,
                       input logic [15:0] w, input logic no_read_while_write_section);
    repeat (dly) @(posedge clk_i);
    store_o <= !ld;
    load_o <= ld;
    z_o <= ld ? z : {z[15:1], 1'b0};
    {r1_o, r0_o} <= w;
    no_read_while_write_section_o <= no_read_while_write_section;
    @(posedge clk_i);
    store_o <= 1'b0;
    load_o <= 1'b0;
    // Operands are stale once the pulse is over
    z_o <= ~z;
    {r1_o, r0_o} <= ~w;
  endtask
endmodule // spf_core_model
`default_nettype wire

/* File: testbench/spf_self_program_flash_control_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------
// Port checker
// --------------------------------------------------------------
module spf_self_program_flash_control_checker #(
  parameter [31:0] PROG_CYCLES = 32'h0000_0014
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  // Processor side
  input  wire logic       store_program_instruction_i,
  input  wire logic       load_program_instruction_i,
  input  wire logic       global_int_en_i,
  input  wire logic       flash_erase_o,
  input  wire logic       flash_write_o,
  input  wire logic       cpu_stall_o,
  input  wire logic       load_special_o,
  input  wire logic       rww_access_block_o,
  input  wire logic       ready_irq_o
);
  logic [31:0] op_cnt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Length of the running erase or write
  always @(posedge clk_i)
    if (sys_rst_i || !(flash_erase_o || flash_write_o))
      op_cnt <= 32'h0000_0000;
    else
      op_cnt <= op_cnt + 32'h0000_0001;

  a_irq_needs_gie: assert property (ready_irq_o |-> global_int_en_i
    && !flash_erase_o && !flash_write_o) else $error("irq while not allowed");
  a_busy_with_op: assert property ($rose(rww_access_block_o) |->
    flash_erase_o || flash_write_o) else $error("busy without operation");
  a_busy_clear: assert property ($fell(rww_access_block_o) |->
    $past(store_program_instruction_i)) else $error("busy cleared alone");
  a_bit5_zero: assert property (reg_rd_i && reg_addr_i == 4'h0 |=>
    !reg_rdata_o[5]) else $error("reserved bit read as one");
  a_stall_op: assert property (cpu_stall_o |->
    flash_erase_o || flash_write_o) else $error("stall without operation");
  a_erase_cause: assert property ($rose(flash_erase_o) |->
    $past(store_program_instruction_i)) else $error("erase without store");
  a_write_cause: assert property ($rose(flash_write_o) |->
    $past(store_program_instruction_i) && !flash_erase_o)
    else $error("write without store");
  a_op_length: assert property ($fell(flash_erase_o || flash_write_o) |->
    op_cnt == PROG_CYCLES + 32'h0000_0002) else $error("operation length");
  a_load_answer: assert property (load_special_o |->
    $past(load_program_instruction_i)) else $error("load answer unasked");
endmodule // spf_self_program_flash_control_checker

bind spf_self_program_flash_control spf_self_program_flash_control_checker
  #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .store_program_instruction_i(store_program_instruction_i),
  .load_program_instruction_i(load_program_instruction_i),
  .global_int_en_i(global_int_en_i), .flash_erase_o(flash_erase_o),
  .flash_write_o(flash_write_o), .cpu_stall_o(cpu_stall_o),
  .load_special_o(load_special_o), .rww_access_block_o(rww_access_block_o),
  .ready_irq_o(ready_irq_o));
`default_nettype wire

/* File: testbench/spf_self_program_flash_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module spf_self_program_flash_control_tb;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i, reg_rd_i, rd_q;
  logic        st, ld, no_read_while_write_section, gie, eboot, vboot, tboot, cerase, fer, fwr;
  logic        stall, lsp, irq, busy, xprog, xver, flock, block;
  logic        srf, lrf, iblk;
  logic [3:0]  reg_addr_i;
  logic [5:0]  w, fword;
  logic [6:0]  pg, fpage;
  logic [7:0]  reg_wdata_i, rdata, r0, r1, fuse, ldata;
  logic [15:0] z, wd, fdata;
  logic [7:0]  exp_q[$];
  int          fails = 0, tests_run = 0, m;

  always #4 clk_i = ~clk_i;

  spf_core_model core_u (.clk_i(clk_i), .store_o(st), .load_o(ld),
    .z_o(z), .r0_o(r0), .r1_o(r1), .no_read_while_write_section_o(no_read_while_write_section));

  spf_self_program_flash_control #(.PROG_CYCLES(32'h0000_0014)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(rdata), .store_program_instruction_i(st),
    .load_program_instruction_i(ld), .z_ptr_i(z), .r0_i(r0), .r1_i(r1),
    .global_int_en_i(gie), .exec_in_boot_i(eboot),
    .vectors_in_boot_i(vboot), .target_in_boot_i(tboot),
    .target_in_no_read_while_write_section_i(no_read_while_write_section), .fuse_byte_i(fuse), .chip_erase_i(cerase),
    .flash_erase_o(fer), .flash_write_o(fwr), .flash_page_o(fpage),
    .flash_word_i(fword), .flash_wdata_o(fdata), .cpu_stall_o(stall),
    .load_data_o(ldata), .load_special_o(lsp), .store_refused_o(srf),
    .load_refused_o(lrf), .int_block_o(iblk), .rww_access_block_o(busy),
    .ext_prog_block_o(xprog), .ext_verify_block_o(xver),
    .fuse_lock_o(flock), .boot_lock_lock_o(block), .ready_irq_o(irq));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic wait_op(input logic lvl);
    int n;
    n = 0;
    @(negedge clk_i);
    while ((fer | fwr) !== lvl && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk(fer | fwr, lvl);
    @(posedge clk_i);
  endtask

  // Read data stand one cycle after the strobe
  always @(posedge clk_i) begin
    rd_q <= reg_rd_i;
    if (rd_q && exp_q.size() > 0)
      chk(rdata, exp_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    complete_run;
  end

  initial begin
    void'($urandom(89));
    {reg_wr_i, reg_rd_i, gie, eboot, vboot, tboot, cerase} = 7'h00;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    fword = 6'h00;
    fuse = 8'($urandom);
    w = 6'($urandom);
    wd = 16'($urandom);
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    @(posedge clk_i);
    rd(4'h1, 8'hFF);
    @(posedge clk_i);
    rd(4'h7, 8'h00);
    $display("test reset done");
    // ----------------------------------------------------------
    // Buffer fill, late store, time out, discard
    // ----------------------------------------------------------
    wr(4'h0, 8'h01);
    core_u.issue(1'b0, 3, {9'h000, w, 1'b0}, wd, 1'b0);
    rd(4'h0, 8'h00);
    fword <= w;
    repeat (2) @(posedge clk_i);
    chk(fdata, wd);
    wr(4'h0, 8'h01);
    repeat (5) @(posedge clk_i);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h01);
    core_u.issue(1'b0, 0, {9'h000, w, 1'b0}, ~wd, 1'b0);
    wr(4'h0, 8'h11);
    repeat (5) @(posedge clk_i);
    chk(fdata, 16'hFFFF);
    $display("test buffer done");
    // ----------------------------------------------------------
    // Erase and write
    // ----------------------------------------------------------
    for (m = 0; m < 2; m++) begin
      pg = 7'($urandom);
      wr(4'h0, 8'h03);
      core_u.issue(1'b0, 0, {2'b00, pg, 7'h00}, wd, 1'b0);
      wait_op(1'b1);
      chk(fpage, pg);
      chk({busy, stall}, 2'b10);
      rd(4'h0, 8'h43);
      wr(4'h0, 8'h11);
      wait_op(1'b0);
      rd(4'h0, 8'h40);
      wr(4'h0, m ? 8'h01 : 8'h11);
      core_u.issue(1'b0, 1, 16'h0000, wd, 1'b0);
      rd(4'h0, 8'h00);
    end
    pg = 7'($urandom);
    wr(4'h0, 8'h05);
    core_u.issue(1'b0, 2, {2'b00, pg, 7'h00}, wd, 1'b1);
    wait_op(1'b1);
    chk({fwr, stall, busy, 6'h00, fpage}, {3'b110, 6'h00, pg});
    wait_op(1'b0);
    rd(4'h0, 8'h00);
    $display("test program done");
    // ----------------------------------------------------------
    // Lock and fuse bits
    // ----------------------------------------------------------
    for (m = 0; m < 2; m++) begin
      wr(4'h0, 8'h09);
      core_u.issue(1'b1, 2, {15'h0000, m[0]}, wd, 1'b0);
      @(negedge clk_i);
      chk({lsp, ldata}, {1'b1, m ? fuse : 8'hFF});
      repeat (4) @(posedge clk_i);
    end
    wr(4'h0, 8'h09);
    core_u.issue(1'b0, 0, wd, {wd[15:8], 8'hF3}, 1'b0);
    rd(4'h1, 8'hF3);
    wr(4'h0, 8'h03);
    fork
      core_u.issue(1'b0, 0, 16'h0000, wd, 1'b0);
      begin
        @(negedge clk_i);
        chk(srf, 1'b1);
      end
    join
    repeat (3) @(posedge clk_i);
    chk(fer, 1'b0);
    repeat (4) @(posedge clk_i);
    {eboot, vboot} <= 2'b10;
    fork
      core_u.issue(1'b1, 0, 16'h0000, wd, 1'b0);
      begin
        @(negedge clk_i);
        chk(lrf, 1'b1);
      end
    join
    {eboot, vboot} <= 2'b01;
    @(posedge clk_i);
    chk(iblk, 1'b1);
    {eboot, vboot} <= 2'b00;
    wr(4'h0, 8'h09);
    core_u.issue(1'b0, 0, wd, 16'h00F0, 1'b0);
    repeat (2) @(posedge clk_i);
    chk({xprog, xver, flock, block}, 4'hF);
    cerase <= 1'b1;
    @(posedge clk_i);
    cerase <= 1'b0;
    rd(4'h1, 8'hFF);
    $display("test lock done");
    // ----------------------------------------------------------
    // Refused patterns and ready interrupt
    // ----------------------------------------------------------
    for (m = 0; m < 32; m++)
      if (!(m inside {1, 3, 5, 9, 17})) begin
        wr(4'h0, m[7:0]);
        rd(4'h0, 8'h00);
      end
    wr(4'h0, 8'h80);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    gie <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    wr(4'h0, 8'h81);
    @(posedge clk_i);
    chk(irq, 1'b0);
    repeat (5) @(posedge clk_i);
    chk(irq, 1'b1);
    rd(4'h0, 8'h80);
    repeat (3) @(posedge clk_i);
    $display("test patterns done");
    complete_run;
  end
endmodule // spf_self_program_flash_control_tb
`default_nettype wire
